/* File: pllco_pkg.sv */
// shared constants and carriers of the pll clock output control block
package pllco_pkg;

   // apb carrier widths
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PLL_CTRL = 8'h3d;
   localparam logic [7:0] IDX_OUT_DIV = 8'h3e;
   localparam logic [7:0] IDX_PIN_GPIO = 8'h30;

   // field positions of the pll and clock pin control register
   localparam int CTRL_SEL_MSB = 7;
   localparam int CTRL_SEL_LSB = 4;
   localparam int CTRL_EN_BIT = 3;
   localparam int CTRL_PD_BIT = 2;
   localparam int CTRL_FB_MSB = 1;
   localparam int CTRL_FB_LSB = 0;

   // field positions of the pin gpio register
   localparam int GPIO_OUT_BIT = 0;
   localparam int GPIO_DRV_BIT = 1;
   localparam int GPIO_IN_BIT = 2;

   // values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] OUTDIV_RST = 8'h08;
   localparam logic [1:0] GPIO_RST = 2'h0;

   // clock output select codes
   localparam logic [3:0] SEL_GPIO = 4'h0;
   localparam logic [3:0] SEL_PLL = 4'h1;
   localparam logic [3:0] SEL_LOW = 4'h2;
   localparam logic [3:0] SEL_HIGH = 4'h3;
   localparam logic [3:0] SEL_XTAL = 4'h4;
   localparam logic [3:0] SEL_XTAL_D2 = 4'h5;
   localparam logic [3:0] SEL_XTAL_D4 = 4'h6;
   localparam logic [3:0] SEL_XTAL_D8 = 4'h7;
   localparam logic [3:0] SEL_TMR0 = 4'h8;
   localparam logic [3:0] SEL_TMR1 = 4'h9;
   localparam logic [3:0] SEL_TMR2 = 4'ha;
   localparam logic [3:0] SEL_TMR3 = 4'hb;

   // feedback divider codes and their multipliers
   localparam logic [1:0] FB_CODE_27 = 2'h1;
   localparam logic [1:0] FB_CODE_28 = 2'h2;
   localparam logic [4:0] FB_MULT_23 = 5'h17;
   localparam logic [4:0] FB_MULT_27 = 5'h1b;
   localparam logic [4:0] FB_MULT_28 = 5'h1c;

   // usable output divider settings
   localparam logic [7:0] OUTDIV_MIN = 8'h08;
   localparam logic [7:0] OUTDIV_MAX = 8'hfe;

   // reference phase counter width, gives undivided and /2 /4 /8 taps
   localparam int REF_CNT_W = 4;
   localparam int TIMER_COUNT = 4;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [APB_AW-1:0] paddr;
      logic [APB_DW-1:0] pwdata;
   } pllco_apb_req_t;

   // apb answer to the master
   typedef struct packed {
      logic [APB_DW-1:0] prdata;
      logic pready;
      logic pslverr;
   } pllco_apb_rsp_t;

   // two-way auxiliary clock pin, output enable low while driving
   typedef struct packed {
      logic pinOut;
      logic pinOeN;
   } pllco_pin_t;

   // apb slave states
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_ANSWER = 2'b10
   } pllco_apb_state_t;

   // decoded register selection
   typedef enum logic [3:0] {
      REG_NONE = 4'b0001,
      REG_CTRL = 4'b0010,
      REG_DIV = 4'b0100,
      REG_GPIO = 4'b1000
   } pllco_reg_t;

endpackage

/* File: pllco_clock_out.sv */
`timescale 1ns/1ps

module pllco_clock_out
#(
   parameter int ACC_W = 10
)
(
   input wire logic clock,
   input wire logic rstn,
   input wire pllco_pkg::pllco_apb_req_t apbReq,
   output pllco_pkg::pllco_apb_rsp_t apbRsp,
   input wire logic [pllco_pkg::TIMER_COUNT-1:0] timerOverflow,
   input wire logic pinIn,
   output pllco_pkg::pllco_pin_t auxiliaryClockPin
);
   import pllco_pkg::*;

   // the accumulator must hold twice the largest divider plus a multiplier
   if (ACC_W < 10)
   begin : g_acc_w_check
      $error("pllco_clock_out: ACC_W must be at least 10");
   end

   // software visible registers
   logic [7:0] pllCtrl_q; // select, enable, power down, feedback code
   logic [7:0] outDiv_q; // pll output divider setting
   logic [1:0] gpio_q; // gpio level and drive request

   // apb slave state and answer flops
   pllco_apb_state_t apbState_q;
   logic pready_q;
   logic pslverr_q;
   logic [APB_DW-1:0] prdata_q;

   // clock generation state
   logic [REF_CNT_W-1:0] refCnt_q; // reference phase taps
   logic [ACC_W-1:0] acc_q; // pll phase accumulator
   logic pllPhase_q; // pll output square wave
   logic [TIMER_COUNT-1:0] tmrTog_q; // one toggle flop per timer unit

   // pin flops
   logic pinOut_q;
   logic pinOeN_q;

   // field views of the control register
   logic [3:0] clockOutSelect;
   logic clockOutEnable;
   logic pllPowerDown;
   logic [1:0] pllFeedbackDivider;

   assign clockOutSelect = pllCtrl_q[CTRL_SEL_MSB:CTRL_SEL_LSB];
   assign clockOutEnable = pllCtrl_q[CTRL_EN_BIT];
   assign pllPowerDown = pllCtrl_q[CTRL_PD_BIT];
   assign pllFeedbackDivider = pllCtrl_q[CTRL_FB_MSB:CTRL_FB_LSB];

   // decode an apb byte address into a register; misaligned is unmapped
   function automatic pllco_reg_t regDecode(input logic [APB_AW-1:0] addr);
      pllco_reg_t sel;
      sel = REG_NONE;
      if ((addr[1:0] == 2'h0) && (addr[APB_AW-1:10] == '0))
      begin
         if (addr[9:2] == IDX_PLL_CTRL)
         begin
            sel = REG_CTRL;
         end
         else if (addr[9:2] == IDX_OUT_DIV)
         begin
            sel = REG_DIV;
         end
         else if (addr[9:2] == IDX_PIN_GPIO)
         begin
            sel = REG_GPIO;
         end
      end
      return sel;
   endfunction

   // access phase seen and decoded target
   logic accessPhase;
   logic writeTaken;
   pllco_reg_t regSel;

   assign accessPhase = apbReq.psel && apbReq.penable;
   assign regSel = regDecode(apbReq.paddr);
   // the write lands only on the edge where pready is high
   assign writeTaken = accessPhase && apbReq.pwrite && (apbState_q == APB_ANSWER);

   // apb slave: one wait state, then pready for exactly one cycle
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         apbState_q <= APB_IDLE;
         pready_q <= 1'b0;
      end
      else
      begin
         case (apbState_q)
            APB_IDLE:
            begin
               // first access cycle: raise pready for the next one
               if (accessPhase)
               begin
                  apbState_q <= APB_ANSWER;
                  pready_q <= 1'b1;
               end
            end
            APB_ANSWER:
            begin
               // transfer completes at this edge
               apbState_q <= APB_IDLE;
               pready_q <= 1'b0;
            end
            default:
            begin
               apbState_q <= APB_IDLE;
               pready_q <= 1'b0;
            end
         endcase
      end
   end

   // read data and error are captured when pready is raised
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end
      else if ((apbState_q == APB_IDLE) && accessPhase)
      begin
         pslverr_q <= (regSel == REG_NONE);
         prdata_q <= '0;
         if (!apbReq.pwrite)
         begin
            case (regSel)
               REG_CTRL: prdata_q <= {24'h000000, pllCtrl_q};
               REG_DIV: prdata_q <= {24'h000000, outDiv_q};
               // pin level is reported live so software can read the gpio
               REG_GPIO: prdata_q <= {29'h00000000, pinIn, gpio_q};
               default: prdata_q <= '0;
            endcase
         end
      end
      else if (apbState_q == APB_ANSWER)
      begin
         // error is a one-cycle answer, cleared with pready
         pslverr_q <= 1'b0;
      end
   end

   // control register writes
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         pllCtrl_q <= CTRL_RST;
      end
      else if (writeTaken && (regSel == REG_CTRL))
      begin
         pllCtrl_q <= apbReq.pwdata[7:0];
      end
   end

   // output divider writes; reserved values are stored but never used
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         outDiv_q <= OUTDIV_RST;
      end
      else if (writeTaken && (regSel == REG_DIV))
      begin
         outDiv_q <= apbReq.pwdata[7:0];
      end
   end

   // gpio register writes; the input bit is read only
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         gpio_q <= GPIO_RST;
      end
      else if (writeTaken && (regSel == REG_GPIO))
      begin
         gpio_q <= apbReq.pwdata[GPIO_DRV_BIT:GPIO_OUT_BIT];
      end
   end

   // reference phase counter; bit 0 stands in for the undivided reference
   // because a flop-driven pin cannot run faster than half the clock
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         refCnt_q <= '0;
      end
      else
      begin
         refCnt_q <= refCnt_q + REF_CNT_W'(1);
      end
   end

   // feedback multiplier lookup
   logic [4:0] fbMult;

   always_comb
   begin
      case (pllFeedbackDivider)
         FB_CODE_27: fbMult = FB_MULT_27;
         FB_CODE_28: fbMult = FB_MULT_28;
         default: fbMult = FB_MULT_23;
      endcase
   end

   // pll runs only when powered and the divider is a usable value
   logic pllRun;
   logic [ACC_W-1:0] modulus;
   logic [ACC_W-1:0] accSum;

   assign pllRun = !pllPowerDown && (outDiv_q >= OUTDIV_MIN) && (outDiv_q <= OUTDIV_MAX);
   // half-periods per reference period: fb over twice the divider
   assign modulus = ACC_W'({outDiv_q, 1'b0});
   assign accSum = acc_q + ACC_W'(fbMult);

   // phase accumulator synthesises ref*fb/4/div; at most one toggle a
   // cycle, so very high ratios saturate rather than alias
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         acc_q <= '0;
         pllPhase_q <= 1'b0;
      end
      else if (!pllRun)
      begin
         // power down or reserved divider: output parked low
         acc_q <= '0;
         pllPhase_q <= 1'b0;
      end
      else if (accSum >= modulus)
      begin
         pllPhase_q <= !pllPhase_q;
         if ((accSum - modulus) >= modulus)
         begin
            acc_q <= '0;
         end
         else
         begin
            acc_q <= accSum - modulus;
         end
      end
      else
      begin
         acc_q <= accSum;
      end
   end

   // one toggle flop per timer unit, flipped on each overflow pulse
   generate
      for (genvar t = 0; t < TIMER_COUNT; t++)
      begin : g_tmr
         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
            begin
               tmrTog_q[t] <= 1'b0;
            end
            else if (timerOverflow[t])
            begin
               tmrTog_q[t] <= !tmrTog_q[t];
            end
         end
      end
   endgenerate

   // pin source selection
   logic pinOut_d;
   logic pinOeN_d;

   always_comb
   begin
      pinOut_d = 1'b0;
      pinOeN_d = 1'b1;
      if (clockOutSelect == SEL_GPIO)
      begin
         // released from clock duty, software owns level and drive
         pinOut_d = gpio_q[GPIO_OUT_BIT];
         pinOeN_d = !gpio_q[GPIO_DRV_BIT];
      end
      else if (!clockOutEnable)
      begin
         // disabled: pin released, nothing driven
         pinOut_d = 1'b0;
         pinOeN_d = 1'b1;
      end
      else
      begin
         pinOeN_d = 1'b0;
         case (clockOutSelect)
            SEL_PLL: pinOut_d = pllPhase_q;
            SEL_LOW: pinOut_d = 1'b0;
            SEL_HIGH: pinOut_d = 1'b1;
            SEL_XTAL: pinOut_d = refCnt_q[0];
            SEL_XTAL_D2: pinOut_d = refCnt_q[1];
            SEL_XTAL_D4: pinOut_d = refCnt_q[2];
            SEL_XTAL_D8: pinOut_d = refCnt_q[3];
            SEL_TMR0: pinOut_d = tmrTog_q[0];
            SEL_TMR1: pinOut_d = tmrTog_q[1];
            SEL_TMR2: pinOut_d = tmrTog_q[2];
            SEL_TMR3: pinOut_d = tmrTog_q[3];
            // reserved codes drive a quiet low instead of garbage
            default: pinOut_d = 1'b0;
         endcase
      end
   end

   // pin flops; one cycle of latency from every source
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         pinOut_q <= 1'b0;
         pinOeN_q <= 1'b1;
      end
      else
      begin
         pinOut_q <= pinOut_d;
         pinOeN_q <= pinOeN_d;
      end
   end

   // outputs straight from flops
   assign apbRsp.prdata = prdata_q;
   assign apbRsp.pready = pready_q;
   assign apbRsp.pslverr = pslverr_q;
   assign auxiliaryClockPin.pinOut = pinOut_q;
   assign auxiliaryClockPin.pinOeN = pinOeN_q;

endmodule

/* File: pllco_clock_out_sva.sv */
`timescale 1ns/1ps
module pllco_clock_out_sva
(
   input wire logic clock,
   input wire logic rstn,
   input wire pllco_pkg::pllco_apb_req_t apbReq,
   input wire pllco_pkg::pllco_apb_rsp_t apbRsp,
   input wire logic [pllco_pkg::TIMER_COUNT-1:0] timerOverflow,
   input wire logic pinIn,
   input wire pllco_pkg::pllco_pin_t auxiliaryClockPin
);
   import pllco_pkg::*;
   logic [7:0] ctrlQ; // mirror of control, built from completed writes
   logic [7:0] divQ;
   logic [1:0] gpioQ;
   logic [17:0] prevQ; // mirror one cycle ago, pin lags a write by one edge
   logic [7:0] ovfQ; // overflow pulses one and two edges back
   logic wrDone;
   logic settled;
   logic live;
   logic pllOff;
   logic [3:0] sel;
   assign wrDone = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
   assign settled = (prevQ == {ctrlQ, divQ, gpioQ});
   assign sel = ctrlQ[CTRL_SEL_MSB:CTRL_SEL_LSB];
   assign live = ctrlQ[CTRL_EN_BIT] && settled;
   assign pllOff = ctrlQ[CTRL_PD_BIT] || divQ < OUTDIV_MIN || divQ > OUTDIV_MAX;
   // refused writes carry pslverr and leave the mirrors alone
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) ctrlQ <= CTRL_RST;
      else if (wrDone && !apbRsp.pslverr && apbReq.paddr == {2'b00, IDX_PLL_CTRL, 2'b00})
         ctrlQ <= apbReq.pwdata[7:0];
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) divQ <= OUTDIV_RST;
      else if (wrDone && !apbRsp.pslverr && apbReq.paddr == {2'b00, IDX_OUT_DIV, 2'b00})
         divQ <= apbReq.pwdata[7:0];
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) gpioQ <= GPIO_RST;
      else if (wrDone && !apbRsp.pslverr && apbReq.paddr == {2'b00, IDX_PIN_GPIO, 2'b00})
         gpioQ <= apbReq.pwdata[1:0];
   // history used to decide when the pin must already reflect the mirrors
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) prevQ <= {CTRL_RST, OUTDIV_RST, GPIO_RST};
      else prevQ <= {ctrlQ, divQ, gpioQ};
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) ovfQ <= 8'h00;
      else ovfQ <= {ovfQ[3:0], timerOverflow};
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   AST_GPIO_MODE: assert property (sel == SEL_GPIO && settled |->
      auxiliaryClockPin.pinOut == gpioQ[0] && auxiliaryClockPin.pinOeN == !gpioQ[1])
      else $error("pin ignores gpio setting");
   AST_PIN_RELEASED: assert property (sel != SEL_GPIO && !ctrlQ[3] && settled |->
      auxiliaryClockPin.pinOeN && !auxiliaryClockPin.pinOut) else $error("pin not released");
   AST_CONST_LEVEL: assert property ((sel == SEL_LOW || sel == SEL_HIGH) && live |->
      !auxiliaryClockPin.pinOeN && auxiliaryClockPin.pinOut == (sel == SEL_HIGH))
      else $error("constant level wrong");
   AST_XTAL_TOGGLE: assert property (sel == SEL_XTAL && live ##1 live |->
      auxiliaryClockPin.pinOut != $past(auxiliaryClockPin.pinOut)) else $error("no ref clock");
   AST_XTAL_HALF: assert property ((sel == SEL_XTAL_D2 && live)[*3] |->
      auxiliaryClockPin.pinOut != $past(auxiliaryClockPin.pinOut, 2)) else $error("bad ref/2");
   AST_XTAL_QUARTER: assert property ((sel == SEL_XTAL_D4 && live)[*5] |->
      auxiliaryClockPin.pinOut != $past(auxiliaryClockPin.pinOut, 4)) else $error("bad ref/4");
   AST_XTAL_EIGHTH: assert property ((sel == SEL_XTAL_D8 && live)[*8] ##1
      (sel == SEL_XTAL_D8 && live) |->
      auxiliaryClockPin.pinOut != $past(auxiliaryClockPin.pinOut, 8)) else $error("bad ref/8");
   AST_TIMER_TOGGLE: assert property (sel[3:2] == 2'b10 && live ##1 live |->
      (auxiliaryClockPin.pinOut != $past(auxiliaryClockPin.pinOut)) == ovfQ[4 + sel[1:0]])
      else $error("timer toggle wrong");
   AST_RESERVED_LOW: assert property (sel >= 4'hc && live |->
      !auxiliaryClockPin.pinOeN && !auxiliaryClockPin.pinOut) else $error("reserved not low");
   AST_PLL_HELD_LOW: assert property ((sel == SEL_PLL && live && pllOff)[*3] |->
      !auxiliaryClockPin.pinOut && !auxiliaryClockPin.pinOeN) else $error("stopped pll moves");
   AST_ONE_WAIT: assert property (apbReq.psel && apbReq.penable && !$past(apbReq.penable) |->
      !apbRsp.pready ##1 apbRsp.pready) else $error("apb wait state wrong");
endmodule
bind pllco_clock_out pllco_clock_out_sva pllco_clock_out_sva_i (.clock(clock), .rstn(rstn),
   .apbReq(apbReq), .apbRsp(apbRsp), .timerOverflow(timerOverflow), .pinIn(pinIn),
   .auxiliaryClockPin(auxiliaryClockPin));

/* File: pllco_clock_out_tb.sv */
`timescale 1ns/1ps
module pllco_clock_out_tb;
   import pllco_pkg::*;
   logic clock;
   logic rstn;
   pllco_apb_req_t apbReq;
   pllco_apb_rsp_t apbRsp;
   logic [TIMER_COUNT-1:0] timerOverflow;
   logic pinIn;
   pllco_pin_t auxiliaryClockPin;
   int n_errors;
   int cmp_count;
   logic [31:0] rdData;
   logic rdErr;
   int toggles;
   logic lastPin;
   // rate cases: control byte, divider, pin toggles expected in 2000 cycles
   logic [7:0] pllCtrl [7] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h18, 8'h19, 8'h1c};
   logic [7:0] pllDiv [7] = '{8'hfa, 8'hfa, 8'h64, 8'h7d, 8'h07, 8'hff, 8'hfa};
   int pllExp [7] = '{92, 108, 280, 184, 0, 0, 0};
   pllco_clock_out pllco_clock_out_i (.clock(clock), .rstn(rstn), .apbReq(apbReq),
      .apbRsp(apbRsp), .timerOverflow(timerOverflow), .pinIn(pinIn),
      .auxiliaryClockPin(auxiliaryClockPin));
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; an edge passes first so psel is never set twice at once
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int waits;
      waits = 0;
      @(posedge clock);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge clock);
      apbReq.penable <= 1'b1;
      // wait however long the answer takes; only the watchdog ends a hang
      while (apbRsp.pready !== 1'b1)
      begin
         @(posedge clock);
         waits++;
      end
      // one wait state: pready is first seen high on the second access edge
      chk(32'(waits), 32'h2);
      rdData = apbRsp.prdata;
      rdErr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, {2'b00, idx, 2'b00}, {24'h0, d});
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0);
      chk(rdData, exp);
   endtask
   task print_verdict;
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // whole run is about 14700 cycles
   initial
   begin
      repeat (30000) @(posedge clock);
      n_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      print_verdict();
   end
   initial
   begin
      rstn = 1'b0;
      apbReq = '0;
      timerOverflow = '0;
      pinIn = 1'b0;
      n_errors = 0;
      cmp_count = 0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      rd(IDX_PLL_CTRL, 32'h0);
      rd(IDX_OUT_DIV, 32'h8);
      chk({30'h0, auxiliaryClockPin}, 32'h1);
      xfer(1'b0, 12'h004, 32'h0);
      chk({31'h0, rdErr}, 32'h1);
      chk(rdData, 32'h0);
      // misaligned write is refused and leaves control alone
      xfer(1'b1, {2'b00, IDX_PLL_CTRL, 2'b01}, 32'hff);
      chk({31'h0, rdErr}, 32'h1);
      rd(IDX_PLL_CTRL, 32'h0);
      // input bit is read only, so its write is dropped
      wr(IDX_PIN_GPIO, 8'h07);
      rd(IDX_PIN_GPIO, 32'h3);
      pinIn <= 1'b1;
      rd(IDX_PIN_GPIO, 32'h7);
      chk({30'h0, auxiliaryClockPin}, 32'h2);
      // every select code enabled then disabled, timers pulsing meanwhile
      for (int s = 0; s < 16; s++)
         for (int e = 1; e >= 0; e--)
         begin
            wr(IDX_PLL_CTRL, {s[3:0], e[0], 3'b000});
            for (int k = 0; k < 6; k++)
            begin
               @(posedge clock);
               timerOverflow <= 4'(k + s);
               @(posedge clock);
               timerOverflow <= 4'h0;
            end
            if (s == 0) chk({30'h0, auxiliaryClockPin}, 32'h2);
            else if (e == 0) chk({30'h0, auxiliaryClockPin}, 32'h1);
            else if (s == 2 || s >= 12) chk({30'h0, auxiliaryClockPin}, 32'h0);
            else if (s == 3) chk({30'h0, auxiliaryClockPin}, 32'h2);
         end
      rd(IDX_PLL_CTRL, 32'hf0);
      // toggle count gives the pll rate; one toggle of slack for start phase
      for (int i = 0; i < 7; i++)
      begin
         wr(IDX_OUT_DIV, pllDiv[i]);
         wr(IDX_PLL_CTRL, pllCtrl[i]);
         repeat (10) @(posedge clock);
         toggles = 0;
         lastPin = auxiliaryClockPin.pinOut;
         repeat (2000)
         begin
            @(posedge clock);
            if (auxiliaryClockPin.pinOut !== lastPin) toggles++;
            lastPin = auxiliaryClockPin.pinOut;
         end
         // a stopped pll must not move at all
         if (pllExp[i] == 0)
            chk(32'(toggles), 32'h0);
         else
            chk(32'(toggles > pllExp[i] - 2 && toggles < pllExp[i] + 2), 32'h1);
      end
      rd(IDX_OUT_DIV, 32'hfa);
      // reset in mid-run returns registers and pin to their reset state
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      chk({30'h0, auxiliaryClockPin}, 32'h1);
      rd(IDX_PLL_CTRL, 32'h0);
      rd(IDX_OUT_DIV, 32'h8);
      print_verdict();
   end
endmodule
